//--- logic/gql_limiter_regs.vh
// constants for the group qos resource limiter
// assumes inclusion by the limiter and its per-engine dispatch gate
`ifndef GQL_LIMITER_REGS_VH
`define GQL_LIMITER_REGS_VH

// structure
`define GQL_NUM_GROUPS 4
`define GQL_NUM_ENGINES 4
`define GQL_GRP_W 2
`define GQL_RB_W 8
`define GQL_INP_W 4
`define GQL_FRAC_W 4
`define GQL_BW_WIN 8'd16

// capability values
`define GQL_TOTAL_READ_BUFFERS 8'h4A
`define GQL_MAX_WORK_INP 4'h8
`define GQL_MAX_BATCH_INP 4'h4
`define GQL_CAP_INP_LIMIT 1'b1
`define GQL_CAP_BW_LIMIT 1'b1
`define GQL_CAP_GLOBAL_RB 1'b1

// group capability word fields
`define GQL_GCAP_TOTAL_LSB 0
`define GQL_GCAP_INP_BIT 8
`define GQL_GCAP_BW_BIT 9
`define GQL_GCAP_GLB_BIT 10

// engine capability word fields
`define GQL_ECAP_WORK_LSB 0
`define GQL_ECAP_BATCH_LSB 4

// reset values
`define GQL_RST_COUNT 8'h00

`endif

//--- logic/gql_engine_gate.v
// per-engine in-progress gate: counts work and batch descriptors in flight
// assumes dispatch and completion strobes from the same clock domain
`timescale 1ns/1ns
`default_nettype none
`include "gql_limiter_regs.vh"

module gql_engine_gate (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // limits in force for this engine
  input wire [`GQL_INP_W-1:0] work_limit_in,
  input wire [`GQL_INP_W-1:0] batch_limit_in,
  // dispatch and completion events
  input wire work_disp_in,
  input wire batch_disp_in,
  input wire work_done_in,
  input wire batch_done_in,
  // stall status
  output wire work_full_out,
  output wire batch_full_out
);

  reg [`GQL_INP_W-1:0] work_cnt_q;
  reg [`GQL_INP_W-1:0] batch_cnt_q;

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      work_cnt_q <= {`GQL_INP_W{1'b0}};
      batch_cnt_q <= {`GQL_INP_W{1'b0}};
    end else begin
      if (work_disp_in && !work_done_in)
        work_cnt_q <= work_cnt_q + 1'b1;
      else if (!work_disp_in && work_done_in && work_cnt_q != 0)
        work_cnt_q <= work_cnt_q - 1'b1;
      if (batch_disp_in && !batch_done_in)
        batch_cnt_q <= batch_cnt_q + 1'b1;
      else if (!batch_disp_in && batch_done_in && batch_cnt_q != 0)
        batch_cnt_q <= batch_cnt_q - 1'b1;
    end
  end

  // stall at the limit; completion frees a slot next cycle see RULE13
  assign work_full_out = (work_cnt_q >= work_limit_in);
  assign batch_full_out = (batch_cnt_q >= batch_limit_in);

endmodule // gql_engine_gate
`default_nettype wire

//--- logic/gql_limiter.v
// group qos resource limiter: read buffer pool, in-progress caps, bandwidth
// assumes configuration ports are held steady while engines run
//
// Overview of operation
// RULE1: fixed buffer pool, size reported in capability
// RULE2: buffers granted to engines for memory reads
// RULE3: reserved buffers usable only by owning group
// RULE4: group total never exceeds its allowed count
// RULE5: global limit restricts groups it applies to
// RULE6: software keeps reserved sum within the pool
// RULE7: software sets allowed at least four per engine
// RULE8: software keeps allowed within reserved plus unreserved
// RULE9: unreserved equals pool minus all reserved counts
// RULE10: engine capability reports work and batch maxima
// RULE11: group in-progress limits apply per engine
// RULE12: flags select limits as fraction of maximum
// RULE13: dispatch stalls at limit until a completion
// RULE14: stalled work queue fills and back-pressures software
// RULE15: global pool shared by all flagged groups
// RULE16: flagged groups still obey their allowed count
// RULE17: software sets second class for slow memory
// RULE18: software marks slow addresses per descriptor
// RULE19: bandwidth limits accepted as fraction of maximum
// RULE20: throttle engine when group usage reaches limit
// RULE21: bandwidth never exceeds implementation maximum
// RULE22: per-address flag selects one of two classes
// RULE23: blocked read request waits, never dropped
`timescale 1ns/1ns
`default_nettype none
`include "gql_limiter_regs.vh"

module gql_limiter (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // group configuration, packed one field per group
  input wire [`GQL_NUM_GROUPS*`GQL_RB_W-1:0] rb_reserved_in,
  input wire [`GQL_NUM_GROUPS*`GQL_RB_W-1:0] rb_allowed_in,
  input wire [`GQL_NUM_GROUPS-1:0] use_global_in,
  input wire [`GQL_NUM_GROUPS*`GQL_INP_W-1:0] work_inp_limit_in,
  input wire [`GQL_NUM_GROUPS*`GQL_INP_W-1:0] batch_inp_limit_in,
  input wire [`GQL_NUM_GROUPS*3-1:0] first_traffic_class_field_in,
  input wire [`GQL_NUM_GROUPS*3-1:0] second_traffic_class_field_in,
  // group flags: fractional modes and bandwidth limits
  input wire [`GQL_NUM_GROUPS-1:0] inp_frac_mode_in,
  input wire [`GQL_NUM_GROUPS*`GQL_FRAC_W-1:0] rd_bw_limit_in,
  input wire [`GQL_NUM_GROUPS*`GQL_FRAC_W-1:0] wr_bw_limit_in,
  // general configuration
  input wire [`GQL_RB_W-1:0] global_rb_limit_in,
  // engine to group map, two bits per engine
  input wire [`GQL_NUM_ENGINES*`GQL_GRP_W-1:0] engine_group_in,
  // read buffer requests and releases per engine
  input wire [`GQL_NUM_ENGINES-1:0] rb_req_in,
  input wire [`GQL_NUM_ENGINES-1:0] rb_rel_in,
  input wire [`GQL_NUM_ENGINES-1:0] rd_beat_in,
  input wire [`GQL_NUM_ENGINES-1:0] wr_beat_in,
  input wire [`GQL_NUM_ENGINES-1:0] tc_sel_in,
  // descriptor dispatch from the work queue arbiter
  input wire [`GQL_NUM_ENGINES-1:0] wq_work_valid_in,
  input wire [`GQL_NUM_ENGINES-1:0] wq_batch_valid_in,
  input wire [`GQL_NUM_ENGINES-1:0] work_done_in,
  input wire [`GQL_NUM_ENGINES-1:0] batch_done_in,
  // grants and dispatch acceptance
  output reg [`GQL_NUM_ENGINES-1:0] rb_grant_out,
  output reg [`GQL_NUM_ENGINES-1:0] work_dispatch_out,
  output reg [`GQL_NUM_ENGINES-1:0] batch_dispatch_out,
  output reg [`GQL_NUM_ENGINES-1:0] throttle_out,
  output reg [`GQL_NUM_ENGINES*3-1:0] traffic_class_out,
  // capability and status
  output reg [15:0] group_capability_reg_out,
  output reg [7:0] engine_capability_reg_out,
  output reg [`GQL_RB_W-1:0] unreserved_out,
  output reg [`GQL_NUM_GROUPS*`GQL_RB_W-1:0] group_in_use_out,
  output reg [`GQL_RB_W-1:0] global_in_use_out
);

  localparam NG = `GQL_NUM_GROUPS;
  localparam NE = `GQL_NUM_ENGINES;
  localparam RW = `GQL_RB_W;
  localparam IW = `GQL_INP_W;
  localparam FW = `GQL_FRAC_W;

  function [RW-1:0] fld_rb;
    input [NG*RW-1:0] v;
    input [`GQL_GRP_W-1:0] g;
    begin
      fld_rb = v[g*RW +: RW];
    end
  endfunction

  function [FW-1:0] fld_frac;
    input [NG*FW-1:0] v;
    input [`GQL_GRP_W-1:0] g;
    begin
      fld_frac = v[g*FW +: FW];
    end
  endfunction

  // beats of one group this cycle; unthrottled engines sharing a group all count
  function [2:0] grp_beats;
    input [NE-1:0] beat;
    input [NE-1:0] thr;
    input [NE*`GQL_GRP_W-1:0] map;
    input [`GQL_GRP_W-1:0] grp;
    integer n;
    begin
      grp_beats = 3'h0;
      for (n = 0; n < NE; n = n + 1)
        if (beat[n] && !thr[n] && map[n*`GQL_GRP_W +: `GQL_GRP_W] == grp)
          grp_beats = grp_beats + 1'b1;
    end
  endfunction

  // fraction of max, in sixteenths, never below one see RULE12
  function [IW-1:0] scale_limit;
    input [IW-1:0] raw;
    input [IW-1:0] maxv;
    input mode;
    reg [2*IW-1:0] prod;
    reg [IW-1:0] lim;
    begin
      prod = raw * maxv;
      lim = mode ? prod[2*IW-1:IW] : raw;
      if (lim == 0)
        lim = {{(IW-1){1'b0}}, 1'b1};
      if (lim > maxv)
        lim = maxv;
      scale_limit = lim;
    end
  endfunction

  // pool bookkeeping
  reg [RW-1:0] grp_use_q [0:NG-1];
  reg [RW-1:0] glb_use_q;
  reg [RW-1:0] rd_cnt_q [0:NG-1];
  reg [RW-1:0] wr_cnt_q [0:NG-1];
  reg [4:0] win_q;
  reg [RW-1:0] res_sum;
  reg [RW-1:0] unres;
  reg [RW-1:0] shared_use;
  reg [RW-1:0] shared_use_d;
  reg [RW-1:0] grp_use_d [0:NG-1];
  reg [RW-1:0] glb_use_d;
  reg [NE-1:0] grant_d;
  reg [NE-1:0] thr_d;
  reg [`GQL_GRP_W-1:0] g;
  reg [RW-1:0] resv;
  reg [RW-1:0] used;
  reg ok;
  reg [`GQL_GRP_W-1:0] g_b;
  integer i, e_g, e_b, i_c, e_l, e_o;

  // reserved sum and shared usage above the reservations see RULE9
  always @* begin
    res_sum = {RW{1'b0}};
    shared_use = {RW{1'b0}};
    for (i = 0; i < NG; i = i + 1) begin
      res_sum = res_sum + rb_reserved_in[i*RW +: RW];
      if (grp_use_q[i] > rb_reserved_in[i*RW +: RW])
        shared_use = shared_use + grp_use_q[i] - rb_reserved_in[i*RW +: RW];
    end
    unres = (res_sum > `GQL_TOTAL_READ_BUFFERS) ? {RW{1'b0}} :
      `GQL_TOTAL_READ_BUFFERS - res_sum;
  end

  // grant in engine order; counts updated within the loop so two
  // grants in one cycle cannot overrun a limit together
  always @* begin
    for (e_g = 0; e_g < NG; e_g = e_g + 1)
      grp_use_d[e_g] = grp_use_q[e_g];
    glb_use_d = glb_use_q;
    shared_use_d = shared_use;
    grant_d = {NE{1'b0}};
    g = {`GQL_GRP_W{1'b0}};
    resv = {RW{1'b0}};
    used = {RW{1'b0}};
    ok = 1'b0;
    // releases first, so a freed buffer is reusable in the same cycle
    for (e_g = 0; e_g < NE; e_g = e_g + 1) begin
      g = engine_group_in[e_g*`GQL_GRP_W +: `GQL_GRP_W];
      if (rb_rel_in[e_g] && grp_use_d[g] != 0) begin
        if (grp_use_d[g] > fld_rb(rb_reserved_in, g))
          shared_use_d = shared_use_d - 1'b1;
        grp_use_d[g] = grp_use_d[g] - 1'b1;
        if (use_global_in[g] && glb_use_d != 0)
          glb_use_d = glb_use_d - 1'b1;
      end
    end
    for (e_g = 0; e_g < NE; e_g = e_g + 1) begin
      g = engine_group_in[e_g*`GQL_GRP_W +: `GQL_GRP_W];
      resv = fld_rb(rb_reserved_in, g);
      used = grp_use_d[g];
      // inside its reservation, or taking from the unreserved share
      ok = (used < resv) || (shared_use_d < unres); // see RULE3
      if (used >= fld_rb(rb_allowed_in, g))
        ok = 1'b0; // see RULE4 see RULE16
      if (use_global_in[g] && glb_use_d >= global_rb_limit_in)
        ok = 1'b0; // see RULE5
      if (rb_req_in[e_g] && ok && !rb_grant_out[e_g]) begin
        grant_d[e_g] = 1'b1; // see RULE2
        if (used >= resv)
          shared_use_d = shared_use_d + 1'b1;
        grp_use_d[g] = used + 1'b1;
        if (use_global_in[g])
          glb_use_d = glb_use_d + 1'b1; // see RULE15
      end
      // refused requests stay pending at the port see RULE23
    end
  end

  // bandwidth windows: throttle once usage meets fraction of window
  always @* begin
    thr_d = {NE{1'b0}};
    for (e_b = 0; e_b < NE; e_b = e_b + 1) begin
      g_b = engine_group_in[e_b*`GQL_GRP_W +: `GQL_GRP_W];
      if (`GQL_CAP_BW_LIMIT == 1'b1) begin // see RULE19
        if (fld_frac(rd_bw_limit_in, g_b) != 0 &&
            rd_cnt_q[g_b] >= {4'h0, fld_frac(rd_bw_limit_in, g_b)})
          thr_d[e_b] = 1'b1; // see RULE20
        if (fld_frac(wr_bw_limit_in, g_b) != 0 &&
            wr_cnt_q[g_b] >= {4'h0, fld_frac(wr_bw_limit_in, g_b)})
          thr_d[e_b] = 1'b1;
      end
    end
  end

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      for (i_c = 0; i_c < NG; i_c = i_c + 1) begin
        grp_use_q[i_c] <= `GQL_RST_COUNT;
        rd_cnt_q[i_c] <= `GQL_RST_COUNT;
        wr_cnt_q[i_c] <= `GQL_RST_COUNT;
      end
      glb_use_q <= `GQL_RST_COUNT;
      win_q <= 5'h00;
    end else begin
      for (i_c = 0; i_c < NG; i_c = i_c + 1)
        grp_use_q[i_c] <= grp_use_d[i_c];
      glb_use_q <= glb_use_d;
      win_q <= (win_q == `GQL_BW_WIN - 1) ? 5'h00 : win_q + 1'b1;
      // one beat per engine per cycle caps bandwidth at maximum see RULE21
      for (i_c = 0; i_c < NG; i_c = i_c + 1) begin
        if (win_q == `GQL_BW_WIN - 1) begin
          rd_cnt_q[i_c] <= `GQL_RST_COUNT;
          wr_cnt_q[i_c] <= `GQL_RST_COUNT;
        end else begin
          rd_cnt_q[i_c] <= rd_cnt_q[i_c] + grp_beats(rd_beat_in,
            throttle_out, engine_group_in, i_c[`GQL_GRP_W-1:0]);
          wr_cnt_q[i_c] <= wr_cnt_q[i_c] + grp_beats(wr_beat_in,
            throttle_out, engine_group_in, i_c[`GQL_GRP_W-1:0]);
        end
      end
    end
  end

  // per-engine limits and dispatch gates see RULE11
  wire [NE-1:0] work_full;
  wire [NE-1:0] batch_full;
  reg [NE*IW-1:0] work_lim;
  reg [NE*IW-1:0] batch_lim;

  always @* begin
    work_lim = {(NE*IW){1'b0}};
    batch_lim = {(NE*IW){1'b0}};
    for (e_l = 0; e_l < NE; e_l = e_l + 1) begin
      work_lim[e_l*IW +: IW] = scale_limit(
        work_inp_limit_in[engine_group_in[e_l*2 +: 2]*IW +: IW],
        `GQL_MAX_WORK_INP, inp_frac_mode_in[engine_group_in[e_l*2 +: 2]]);
      batch_lim[e_l*IW +: IW] = scale_limit(
        batch_inp_limit_in[engine_group_in[e_l*2 +: 2]*IW +: IW],
        `GQL_MAX_BATCH_INP, inp_frac_mode_in[engine_group_in[e_l*2 +: 2]]);
    end
  end

  genvar ge;
  generate
    for (ge = 0; ge < NE; ge = ge + 1) begin : eng
      gql_engine_gate gql_engine_gate_inst (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .work_limit_in(work_lim[ge*IW +: IW]),
        .batch_limit_in(batch_lim[ge*IW +: IW]),
        .work_disp_in(work_dispatch_out[ge]),
        .batch_disp_in(batch_dispatch_out[ge]),
        .work_done_in(work_done_in[ge]),
        .batch_done_in(batch_done_in[ge]),
        .work_full_out(work_full[ge]),
        .batch_full_out(batch_full[ge])
      );
    end
  endgenerate

  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rb_grant_out <= {NE{1'b0}};
      work_dispatch_out <= {NE{1'b0}};
      batch_dispatch_out <= {NE{1'b0}};
      throttle_out <= {NE{1'b0}};
      traffic_class_out <= {(NE*3){1'b0}};
      group_capability_reg_out <= 16'h0000;
      engine_capability_reg_out <= 8'h00;
      unreserved_out <= `GQL_RST_COUNT;
      group_in_use_out <= {(NG*RW){1'b0}};
      global_in_use_out <= `GQL_RST_COUNT;
    end else begin
      rb_grant_out <= grant_d;
      throttle_out <= thr_d;
      // a stalled dispatch leaves the descriptor in the queue, whose
      // fill back-pressures submitters see RULE14
      work_dispatch_out <= wq_work_valid_in & ~work_full &
        ~work_dispatch_out; // see RULE13
      batch_dispatch_out <= wq_batch_valid_in & ~batch_full &
        ~batch_dispatch_out;
      for (e_o = 0; e_o < NE; e_o = e_o + 1)
        traffic_class_out[e_o*3 +: 3] <= tc_sel_in[e_o] ?
          second_traffic_class_field_in[engine_group_in[e_o*2 +: 2]*3 +: 3] :
          first_traffic_class_field_in[engine_group_in[e_o*2 +: 2]*3 +: 3];
      // see RULE22
      group_capability_reg_out <= {5'h00, `GQL_CAP_GLOBAL_RB,
        `GQL_CAP_BW_LIMIT, `GQL_CAP_INP_LIMIT,
        `GQL_TOTAL_READ_BUFFERS}; // see RULE1
      engine_capability_reg_out <= (`GQL_CAP_INP_LIMIT == 1'b1) ?
        {`GQL_MAX_BATCH_INP, `GQL_MAX_WORK_INP} : 8'h00; // see RULE10
      unreserved_out <= unres;
      for (e_o = 0; e_o < NG; e_o = e_o + 1)
        group_in_use_out[e_o*RW +: RW] <= grp_use_q[e_o];
      global_in_use_out <= glb_use_q;
    end
  end

endmodule // gql_limiter
`default_nettype wire

//--- verif/gql_limiter_chk.sv
// checker: timing and limit relations at the limiter ports
// assumes bind onto gql_limiter, one clock domain
`timescale 1ns/1ns
`default_nettype none
module gql_limiter_chk (
  // clock and reset
  input wire clk_sys_in,
  input wire rst_n_in,
  // configuration
  input wire [31:0] rb_reserved_in,
  input wire [31:0] rb_allowed_in,
  input wire [7:0] global_rb_limit_in,
  input wire [7:0] engine_group_in,
  input wire [11:0] first_traffic_class_field_in,
  input wire [11:0] second_traffic_class_field_in,
  // requests
  input wire [3:0] rb_req_in,
  input wire [3:0] tc_sel_in,
  input wire [3:0] wq_work_valid_in,
  // outputs
  input wire [3:0] rb_grant_out,
  input wire [3:0] work_dispatch_out,
  input wire [11:0] traffic_class_out,
  input wire [15:0] group_capability_reg_out,
  input wire [7:0] engine_capability_reg_out,
  input wire [7:0] unreserved_out,
  input wire [31:0] group_in_use_out,
  input wire [7:0] global_in_use_out
);
  wire [31:0] r = rb_reserved_in;
  wire [31:0] a = rb_allowed_in;
  wire [31:0] u = group_in_use_out;
  wire [7:0] unres_exp = 8'h4A - r[7:0] - r[15:8] - r[23:16] - r[31:24];
  wire [2:0] tc_exp = tc_sel_in[0] ?
    second_traffic_class_field_in[engine_group_in[1:0]*3 +: 3] :
    first_traffic_class_field_in[engine_group_in[1:0]*3 +: 3];
  // edges since reset release, saturating; capabilities settle late
  reg [1:0] up_q;
  always @(posedge clk_sys_in) begin
    up_q <= !rst_n_in ? 2'h0 : (up_q == 2'h3 ? 2'h3 : up_q + 2'h1);
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  chk_cap_total: assert property (
    up_q == 2'h3 |-> group_capability_reg_out[10:0] == 11'h74A)
    else $error("group capability word wrong");
  chk_cap_engine: assert property (
    up_q == 2'h3 |-> engine_capability_reg_out == 8'h48)
    else $error("engine capability word wrong");
  chk_unres_sum: assert property (
    up_q == 2'h3 && $stable(rb_reserved_in) |-> unreserved_out == unres_exp)
    else $error("unreserved count wrong");
  chk_grant_req: assert property (
    rb_grant_out != 4'h0 |-> (rb_grant_out & ~$past(rb_req_in)) == 4'h0)
    else $error("grant without request");
  chk_disp_valid: assert property (
    work_dispatch_out != 4'h0 |->
      (work_dispatch_out & ~$past(wq_work_valid_in)) == 4'h0)
    else $error("dispatch without queued work");
  chk_group_cap: assert property (
    u[7:0] <= a[7:0] && u[15:8] <= a[15:8] &&
    u[23:16] <= a[23:16] && u[31:24] <= a[31:24])
    else $error("group holds more than allowed");
  chk_global_cap: assert property (
    global_in_use_out <= global_rb_limit_in)
    else $error("global pool overrun");
  chk_tc_pick: assert property (
    up_q == 2'h3 && $stable(tc_sel_in) && $stable(engine_group_in) |->
      traffic_class_out[2:0] == tc_exp)
    else $error("traffic class select wrong");
endmodule // gql_limiter_chk

bind gql_limiter gql_limiter_chk gql_limiter_chk_inst (.clk_sys_in,
  .rst_n_in, .rb_reserved_in, .rb_allowed_in, .global_rb_limit_in,
  .engine_group_in, .first_traffic_class_field_in,
  .second_traffic_class_field_in, .rb_req_in, .tc_sel_in, .wq_work_valid_in,
  .rb_grant_out, .work_dispatch_out, .traffic_class_out,
  .group_capability_reg_out, .engine_capability_reg_out, .unreserved_out,
  .group_in_use_out, .global_in_use_out);
`default_nettype wire

//--- verif/test_gql_limiter.sv
// bench: directed scenarios for the qos limiter
// assumes the bound checker; inputs change at falling edges
`timescale 1ns/1ns
`default_nettype none
module test_gql_limiter;
  reg clk_sys_in, rst_n_in;
  reg [31:0] rb_reserved_in, rb_allowed_in;
  reg [15:0] work_inp_limit_in, batch_inp_limit_in;
  reg [15:0] rd_bw_limit_in, wr_bw_limit_in;
  reg [11:0] first_traffic_class_field_in, second_traffic_class_field_in;
  reg [7:0] global_rb_limit_in, engine_group_in;
  reg [3:0] use_global_in, inp_frac_mode_in, rb_req_in, rb_rel_in;
  reg [3:0] rd_beat_in, wr_beat_in, tc_sel_in, wq_work_valid_in;
  reg [3:0] wq_batch_valid_in, work_done_in, batch_done_in;
  wire [3:0] rb_grant_out, work_dispatch_out, batch_dispatch_out;
  wire [3:0] throttle_out;
  wire [11:0] traffic_class_out;
  wire [15:0] group_capability_reg_out;
  wire [7:0] engine_capability_reg_out, unreserved_out, global_in_use_out;
  wire [31:0] group_in_use_out;
  integer bad_count, num_checks, k, i;
  integer gc[0:3], wc[0:3], bc[0:3], th[0:3];
  gql_limiter gql_limiter_inst (.clk_sys_in, .rst_n_in, .rb_reserved_in,
    .rb_allowed_in, .use_global_in, .work_inp_limit_in, .batch_inp_limit_in,
    .first_traffic_class_field_in, .second_traffic_class_field_in,
    .inp_frac_mode_in, .rd_bw_limit_in, .wr_bw_limit_in, .global_rb_limit_in,
    .engine_group_in, .rb_req_in, .rb_rel_in, .rd_beat_in, .wr_beat_in,
    .tc_sel_in, .wq_work_valid_in, .wq_batch_valid_in, .work_done_in,
    .batch_done_in, .rb_grant_out, .work_dispatch_out, .batch_dispatch_out,
    .throttle_out, .traffic_class_out, .group_capability_reg_out,
    .engine_capability_reg_out, .unreserved_out, .group_in_use_out,
    .global_in_use_out);
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // config is set just before this, so it is steady across the release
  task rst;
    begin
      rst_n_in = 1'b0;
      {rb_req_in, rd_beat_in, wr_beat_in, wq_work_valid_in} = 16'h0000;
      wq_batch_valid_in = 4'h0;
      repeat (4) @(negedge clk_sys_in);
      rst_n_in = 1'b1;
      repeat (3) @(negedge clk_sys_in);
    end
  endtask
  // counts grant and dispatch, flags throttle per engine; rel pulses first cycle
  task run(input integer n, input [3:0] rel);
    begin
      {rb_rel_in, work_done_in, batch_done_in} = {3{rel}};
      for (i = 0; i < 4; i = i + 1) begin
        gc[i] = 0; wc[i] = 0; bc[i] = 0; th[i] = 0;
      end
      for (k = 0; k < n; k = k + 1) begin
        @(negedge clk_sys_in);
        if (k == 0) {rb_rel_in, work_done_in, batch_done_in} = 12'h000;
        for (i = 0; i < 4; i = i + 1) begin
          gc[i] = gc[i] + rb_grant_out[i];
          wc[i] = wc[i] + work_dispatch_out[i];
          bc[i] = bc[i] + batch_dispatch_out[i];
          th[i] = th[i] | throttle_out[i];
        end
      end
    end
  endtask
  task t_alloc;
    begin
      rb_reserved_in = 32'h0303_0303;
      rb_allowed_in = 32'h0441_0404;
      rst;
      check(unreserved_out, 8'h3E);
      check(group_capability_reg_out, 16'h074A);
      check(engine_capability_reg_out, 8'h48);
      rb_req_in = 4'h4;
      run(140, 4'h0);
      check(gc[2], 8'h41);
      check(group_in_use_out[23:16], 8'h41);
      rb_req_in = 4'h8;
      run(20, 4'h0);
      check(gc[3], 8'h03);
      run(20, 4'h4);
      check(gc[3], 8'h01);
      $display("alloc test done");
    end
  endtask
  task t_global;
    begin
      rb_reserved_in = 32'h0000_0000;
      rb_allowed_in = 32'h0408_0804;
      use_global_in = 4'h3;
      global_rb_limit_in = 8'h06;
      rst;
      rb_req_in = 4'h1;
      run(20, 4'h0);
      check(gc[0], 8'h04);
      rb_req_in = 4'h6;
      run(30, 4'h0);
      check(gc[1], 8'h02);
      check(gc[2], 8'h08);
      check(global_in_use_out, 8'h06);
      $display("global pool test done");
    end
  endtask
  task t_inp;
    begin
      use_global_in = 4'h0;
      work_inp_limit_in = 16'hF802;
      batch_inp_limit_in = 16'h0010;
      inp_frac_mode_in = 4'h4;
      rst;
      wq_work_valid_in = 4'hD;
      wq_batch_valid_in = 4'h2;
      run(40, 4'h0);
      check(wc[0], 8'h02);
      check(bc[1], 8'h01);
      check(wc[2], 8'h04);
      check(wc[3], 8'h08);
      run(20, 4'h1);
      check(wc[0], 8'h01);
      $display("in-progress test done");
    end
  endtask
  task t_bw;
    begin
      rd_bw_limit_in = 16'h0004;
      wr_bw_limit_in = 16'h0040;
      rst;
      {rd_beat_in, wr_beat_in} = 8'hFF;
      run(32, 4'h0);
      check(th[0], 8'h01);
      check(th[1], 8'h01);
      check(th[2] | th[3], 8'h00);
      $display("bandwidth test done");
    end
  endtask
  task t_tc;
    begin
      first_traffic_class_field_in = 12'h8D1;
      second_traffic_class_field_in = 12'h1F5;
      rst;
      run(3, 4'h0);
      check(traffic_class_out, 12'h8D1);
      tc_sel_in = 4'hF;
      run(3, 4'h0);
      check(traffic_class_out, 12'h1F5);
      tc_sel_in = 4'h5;
      run(3, 4'h0);
      check(traffic_class_out, 12'h9D5);
      $display("traffic class test done");
    end
  endtask
  // engines 0 and 1 share group 0: caps per engine, bandwidth per group
  task t_share;
    begin
      engine_group_in = 8'h50;
      {work_inp_limit_in, rd_bw_limit_in, wr_bw_limit_in} = 48'h0002_0006_0000;
      inp_frac_mode_in = 4'h0;
      rst;
      wq_work_valid_in = 4'h3;
      run(20, 4'h0);
      check(wc[0], 8'h02);
      check(wc[1], 8'h02);
      // two beats a cycle meet a limit of six after three cycles
      rd_beat_in = 4'h3;
      run(2, 4'h0);
      check(th[0] | th[1], 8'h00);
      run(2, 4'h0);
      check(th[0] & th[1], 8'h01);
      $display("shared group test done");
    end
  endtask
  initial begin
    bad_count = 0;
    num_checks = 0;
    rst_n_in = 1'b0;
    {rb_reserved_in, rb_allowed_in, work_inp_limit_in} = 80'h0;
    {batch_inp_limit_in, rd_bw_limit_in, wr_bw_limit_in} = 48'h0;
    {first_traffic_class_field_in, second_traffic_class_field_in} = 24'h0;
    {global_rb_limit_in, use_global_in, inp_frac_mode_in} = 16'h0;
    engine_group_in = 8'hE4;
    {rb_req_in, rb_rel_in, rd_beat_in, wr_beat_in, tc_sel_in} = 20'h0;
    {wq_work_valid_in, wq_batch_valid_in, work_done_in} = 12'h0;
    batch_done_in = 4'h0;
    @(negedge clk_sys_in);
    t_alloc;
    t_global;
    t_inp;
    t_bw;
    t_tc;
    t_share;
    give_verdict;
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge clk_sys_in);
    bad_count = bad_count + 1;
    give_verdict;
  end
endmodule // test_gql_limiter
`default_nettype wire
